// [rtl/ledind_top.sv]
// Behaviour
// RL1: LED condition is OR of optionally inverted inputs
// RL2: Condition true shows active colour, default red flash
// RL3: Condition false shows inactive colour, default off
// RL4: Acknowledge ignored unless latching is enabled
// RL5: Acknowledge clears latch only once causes are gone
// RL6: Latched LED stays active until valid acknowledge
// RL7: Flash colours share one fixed blink phase
`timescale 1ns/100ps
module ledind_top #(
  parameter int unsigned N_SLOTS  = ledind_pkg::N_SLOTS,
  parameter int unsigned POOL_W   = ledind_pkg::POOL_W,
  parameter int unsigned HALF_CYC = ledind_pkg::BLINK_HALF_CYC
) (
  // Clock and reset
  input  wire logic                          core_clk_in,
  input  wire logic                          resetn_in,
  // Internal device signals to choose from
  input  wire logic [POOL_W-1:0]             pool_in,
  // Register port
  input  wire ledind_pkg::ledind_req_t       req_in,
  output logic [ledind_pkg::DATA_W-1:0]      rdata_out,
  // LED drive
  output ledind_pkg::ledind_led_t            led_out
);
  import ledind_pkg::*;

  localparam int unsigned ASG_W = N_SLOTS * SEL_W;

  if (N_SLOTS < 1 || ASG_W > DATA_W || N_SLOTS != ledind_pkg::N_SLOTS) begin : g_chk_slots
    $error("Slot count does not fit the register layout");
  end
  if (POOL_W < 1 || POOL_W >= (1 << SEL_W)) begin : g_chk_pool
    $error("Signal pool must be smaller than the selector range");
  end

  // Pick one pool signal; an unassigned or out of range selector gives zero
  function automatic logic pick(input logic [POOL_W-1:0] pool, input logic [SEL_W-1:0] sel);
    logic bit_v;
    bit_v = 1'b0;
    if (sel != SEL_NONE && int'(sel) < int'(POOL_W)) begin
      bit_v = pool[sel];
    end
    return bit_v;
  endfunction

  // Turn a colour code and blink phase into the two LED drives
  function automatic ledind_led_t drive(input logic [CLR_W-1:0] clr, input logic phase);
    ledind_led_t d;
    d = '0;
    case (clr)
      CLR_GREEN: begin
        d.green = 1'b1;
      end
      CLR_RED: begin
        d.red = 1'b1;
      end
      CLR_RED_FLASH: begin
        d.red = phase;
      end
      CLR_GREEN_FLASH: begin
        d.green = phase;
      end
      default: begin
        d = '0;
      end
    endcase
    return d;
  endfunction

  // Configuration registers
  logic                 latch_en_r;
  logic [CLR_W-1:0]     act_clr_r;
  logic [CLR_W-1:0]     inact_clr_r;
  logic [SEL_W-1:0]     ack_sel_r;
  logic [N_SLOTS-1:0]   invert_r;
  logic [ASG_W-1:0]     assign_r;

  // Block state
  logic                 latched_r;
  logic [N_SLOTS-1:0]   cause_r;
  logic                 ack_sw_r;
  ledind_led_t          led_r;
  logic [DATA_W-1:0]    rdata_r;

  logic [N_SLOTS-1:0]   slot_act;
  logic                 cond;
  logic                 ack_hw;
  logic                 ack;
  logic                 ack_ok;
  logic                 lit;
  logic                 phase;
  logic [CLR_W-1:0]     clr_sel;
  ledind_led_t          led_nxt;
  logic [DATA_W-1:0]    rdata_nxt;
  logic                 wr_ctrl;
  logic                 wr_invert;
  logic                 wr_assign;
  logic                 wr_acksw;

  ledind_blink #(
    .HALF_CYC (HALF_CYC)
  ) u_blink (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .phase_out   (phase)
  );

  // Write decode
  assign wr_ctrl   = req_in.wr && (req_in.addr == REG_CTRL);
  assign wr_invert = req_in.wr && (req_in.addr == REG_INVERT);
  assign wr_assign = req_in.wr && (req_in.addr == REG_ASSIGN);
  assign wr_acksw  = req_in.wr && (req_in.addr == REG_ACKSW);

  // Control register
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      latch_en_r  <= 1'b0;
      act_clr_r   <= RST_ACT_CLR;
      inact_clr_r <= RST_INACT_CLR;
      ack_sel_r   <= RST_ACK_SEL;
    end else if (wr_ctrl) begin
      latch_en_r  <= req_in.wdata[CTRL_LATCH_BIT];
      act_clr_r   <= req_in.wdata[CTRL_ACT_LSB +: CLR_W];
      inact_clr_r <= req_in.wdata[CTRL_INACT_LSB +: CLR_W];
      ack_sel_r   <= req_in.wdata[CTRL_ACK_LSB +: SEL_W];
    end
  end

  // Inversion mask, not inverted after reset
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      invert_r <= RST_INVERT;
    end else if (wr_invert) begin
      invert_r <= req_in.wdata[N_SLOTS-1:0];
    end
  end

  // Signal assignment per slot
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      assign_r <= RST_ASSIGN;
    end else if (wr_assign) begin
      assign_r <= req_in.wdata[ASG_W-1:0];
    end
  end

  // Software acknowledge is a one-cycle pulse
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ack_sw_r <= 1'b0;
    end else begin
      ack_sw_r <= wr_acksw && req_in.wdata[ACKSW_BIT];
    end
  end

  // Inputs come from logic on this clock, so no synchroniser is needed
  always_comb begin
    slot_act = '0;
    for (int i = 0; i < int'(N_SLOTS); i++) begin
      if (assign_r[i*SEL_W +: SEL_W] != SEL_NONE) begin
        slot_act[i] = pick(pool_in, assign_r[i*SEL_W +: SEL_W]) ^ invert_r[i]; // RL1
      end
    end
  end

  assign cond   = |slot_act; // RL1
  assign ack_hw = pick(pool_in, ack_sel_r);
  assign ack    = ack_hw | ack_sw_r;
  // Holding acknowledge does not clear while any cause is still present
  assign ack_ok = latch_en_r && ack && !cond; // RL4 RL5

  // Latch; a fresh pickup in the acknowledge cycle wins over the clear
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      latched_r <= 1'b0;
    end else if (!latch_en_r) begin
      latched_r <= 1'b0; // RL4
    end else if (cond) begin
      latched_r <= 1'b1; // RL6
    end else if (ack_ok) begin
      latched_r <= 1'b0; // RL5
    end
  end

  // Slots that took part in the pickup, kept for software
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cause_r <= '0;
    end else if (!latch_en_r) begin
      cause_r <= '0;
    end else if (ack_ok) begin
      cause_r <= '0;
    end else begin
      cause_r <= cause_r | slot_act;
    end
  end

  assign lit     = cond || (latch_en_r && latched_r); // RL6
  assign clr_sel = lit ? act_clr_r : inact_clr_r; // RL2 RL3
  assign led_nxt = drive(clr_sel, phase); // RL7

  // LED drive is registered, one cycle behind the condition
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      led_r <= '0;
    end else begin
      led_r <= led_nxt;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_nxt = '0;
    case (req_in.addr)
      REG_CTRL: begin
        rdata_nxt[CTRL_LATCH_BIT]            = latch_en_r;
        rdata_nxt[CTRL_ACT_LSB +: CLR_W]     = act_clr_r;
        rdata_nxt[CTRL_INACT_LSB +: CLR_W]   = inact_clr_r;
        rdata_nxt[CTRL_ACK_LSB +: SEL_W]     = ack_sel_r;
      end
      REG_INVERT: begin
        rdata_nxt[N_SLOTS-1:0] = invert_r;
      end
      REG_ASSIGN: begin
        rdata_nxt[ASG_W-1:0] = assign_r;
      end
      REG_STATUS: begin
        rdata_nxt[ST_COND_BIT]  = cond;
        rdata_nxt[ST_LATCH_BIT] = latched_r;
        rdata_nxt[ST_RED_BIT]   = led_r.red;
        rdata_nxt[ST_GREEN_BIT] = led_r.green;
        rdata_nxt[ST_PHASE_BIT] = phase;
        rdata_nxt[ST_LIT_BIT]   = lit;
      end
      REG_CAUSE: begin
        rdata_nxt[N_SLOTS-1:0] = cause_r;
      end
      default: begin
        rdata_nxt = '0;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_r <= '0;
    end else if (req_in.rd) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= '0;
    end
  end

  assign rdata_out = rdata_r;
  assign led_out   = led_r;

endmodule

// [shared/ledind_pkg.sv]
package ledind_pkg;

  // Clock and blink timing
  localparam int unsigned CLK_KHZ        = 200000;
  localparam int unsigned BLINK_HALF_MS  = 500;
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;

  // Sizes
  localparam int unsigned N_SLOTS  = 5;
  localparam int unsigned POOL_W   = 15;
  localparam int unsigned SEL_W    = 4;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned CLR_W    = 3;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_INVERT = 8'h04;
  localparam logic [ADDR_W-1:0] REG_ASSIGN = 8'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_ACKSW  = 8'h10;
  localparam logic [ADDR_W-1:0] REG_CAUSE  = 8'h14;

  // Control register fields
  localparam int unsigned CTRL_LATCH_BIT = 0;
  localparam int unsigned CTRL_ACT_LSB   = 4;
  localparam int unsigned CTRL_INACT_LSB = 8;
  localparam int unsigned CTRL_ACK_LSB   = 16;

  // Status register fields
  localparam int unsigned ST_COND_BIT  = 0;
  localparam int unsigned ST_LATCH_BIT = 1;
  localparam int unsigned ST_RED_BIT   = 2;
  localparam int unsigned ST_GREEN_BIT = 3;
  localparam int unsigned ST_PHASE_BIT = 4;
  localparam int unsigned ST_LIT_BIT   = 5;

  // Software acknowledge bit
  localparam int unsigned ACKSW_BIT = 0;

  // Selector value meaning "not assigned"
  localparam logic [SEL_W-1:0] SEL_NONE = 4'hf;

  // Colour codes
  localparam logic [CLR_W-1:0] CLR_OFF         = 3'h0;
  localparam logic [CLR_W-1:0] CLR_GREEN       = 3'h1;
  localparam logic [CLR_W-1:0] CLR_RED         = 3'h2;
  localparam logic [CLR_W-1:0] CLR_RED_FLASH   = 3'h3;
  localparam logic [CLR_W-1:0] CLR_GREEN_FLASH = 3'h4;

  // Reset values
  localparam logic [CLR_W-1:0]         RST_ACT_CLR   = CLR_RED_FLASH;
  localparam logic [CLR_W-1:0]         RST_INACT_CLR = CLR_OFF;
  localparam logic [N_SLOTS-1:0]       RST_INVERT    = 5'h00;
  localparam logic [SEL_W-1:0]         RST_SLOT0_SEL = 4'h0;
  localparam logic [SEL_W-1:0]         RST_ACK_SEL   = SEL_NONE;
  localparam logic [N_SLOTS*SEL_W-1:0] RST_ASSIGN    = 20'hffff0;

  // Register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } ledind_req_t;

  // LED drive
  typedef struct packed {
    logic red;
    logic green;
  } ledind_led_t;

endpackage

// [rtl/ledind_blink.sv]
`timescale 1ns/100ps
module ledind_blink #(
  parameter int unsigned HALF_CYC = ledind_pkg::BLINK_HALF_CYC
) (
  // Clock and reset
  input  wire logic core_clk_in,
  input  wire logic resetn_in,
  // Phase
  output logic      phase_out
);
  import ledind_pkg::*;

  localparam int unsigned CNT_W = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(HALF_CYC - 1);

  if (HALF_CYC < 1) begin : g_chk
    $error("Blink half period must be at least one cycle");
  end

  logic [CNT_W-1:0] cnt_r;
  logic             phase_r;

  // One shared phase, so both flash colours blink in step
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_r   <= '0;
      phase_r <= 1'b0;
    end else if (cnt_r == CNT_LAST) begin
      cnt_r   <= '0;
      phase_r <= ~phase_r; // RL7
    end else begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  assign phase_out = phase_r;

endmodule

// [test/ledind_props.sv]
`timescale 1ns/100ps
module ledind_props #(
  parameter int unsigned N_SLOTS  = ledind_pkg::N_SLOTS,
  parameter int unsigned POOL_W   = ledind_pkg::POOL_W,
  parameter int unsigned HALF_CYC = ledind_pkg::BLINK_HALF_CYC
) (
  // Clock and reset
  input wire logic                          core_clk_in,
  input wire logic                          resetn_in,
  // Watched ports
  input wire logic [POOL_W-1:0]             pool_in,
  input wire ledind_pkg::ledind_req_t       req_in,
  input wire logic [ledind_pkg::DATA_W-1:0] rdata_out,
  input wire ledind_pkg::ledind_led_t       led_out
);
  import ledind_pkg::*;
  logic [CLR_W-1:0] act_r;
  logic [CLR_W-1:0] inact_r;
  logic [SEL_W-1:0] sel_r;
  logic             latch_r;
  ledind_led_t      prev_r;
  int unsigned      age_r;
  int unsigned      run_r_r;
  int unsigned      run_g_r;
  logic             ack;
  assign ack = (sel_r < POOL_W && pool_in[sel_r]) ||
               (req_in.wr && req_in.addr == REG_ACKSW && req_in.wdata[ACKSW_BIT]);
  function automatic logic has_r(logic [CLR_W-1:0] c);
    return c == CLR_RED || c == CLR_RED_FLASH;
  endfunction
  function automatic logic has_g(logic [CLR_W-1:0] c);
    return c == CLR_GREEN || c == CLR_GREEN_FLASH;
  endfunction
  // Shadow control word; age restarts on each control write so settings can settle
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      act_r   <= RST_ACT_CLR;
      inact_r <= RST_INACT_CLR;
      sel_r   <= RST_ACK_SEL;
      latch_r <= 1'b0;
      age_r   <= 0;
    end else if (req_in.wr && req_in.addr == REG_CTRL) begin
      act_r   <= req_in.wdata[CTRL_ACT_LSB +: CLR_W];
      inact_r <= req_in.wdata[CTRL_INACT_LSB +: CLR_W];
      sel_r   <= req_in.wdata[CTRL_ACK_LSB +: SEL_W];
      latch_r <= req_in.wdata[CTRL_LATCH_BIT];
      age_r   <= 0;
    end else if (age_r < 1000) begin
      age_r <= age_r + 1;
    end
  end
  // Cycles since each LED line last changed
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prev_r  <= '0;
      run_r_r <= 0;
      run_g_r <= 0;
    end else begin
      prev_r  <= led_out;
      run_r_r <= (led_out.red != prev_r.red) ? 0 : run_r_r + 1;
      run_g_r <= (led_out.green != prev_r.green) ? 0 : run_g_r + 1;
    end
  end
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);
  chk_led_exclusive: assert property (!(led_out.red && led_out.green))
    else $error("both lines lit");
  chk_no_red: assert property (!has_r(act_r) && !has_r(inact_r) && !has_r($past(act_r))
      && !has_r($past(inact_r)) |-> !led_out.red)
    else $error("red without red colour");
  chk_no_green: assert property (!has_g(act_r) && !has_g(inact_r) && !has_g($past(act_r))
      && !has_g($past(inact_r)) |-> !led_out.green)
    else $error("green without green colour");
  chk_red_blink: assert property (act_r == CLR_RED_FLASH && inact_r == CLR_RED_FLASH
      && age_r > 3 * HALF_CYC |-> run_r_r < HALF_CYC
      && (led_out.red == prev_r.red || run_r_r == HALF_CYC - 1))
    else $error("red blink period");
  chk_green_blink: assert property (act_r == CLR_GREEN_FLASH && inact_r == CLR_GREEN_FLASH
      && age_r > 3 * HALF_CYC |-> run_g_r < HALF_CYC
      && (led_out.green == prev_r.green || run_g_r == HALF_CYC - 1))
    else $error("green blink period");
  chk_latch_hold: assert property (latch_r && act_r == CLR_RED && inact_r == CLR_OFF
      && age_r > 3 && $past(led_out.red) && !$past(ack) && !$past(ack, 2)
      && !$past(ack, 3) && !$past(ack, 4) |-> led_out.red)
    else $error("latched LED dropped");
  chk_reset_dark: assert property (!$past(resetn_in) |-> led_out == '0 && rdata_out == '0)
    else $error("dark after reset");
endmodule
bind ledind_top ledind_props #(.N_SLOTS(N_SLOTS), .POOL_W(POOL_W), .HALF_CYC(HALF_CYC)) u_props (
  .core_clk_in(core_clk_in),
  .resetn_in(resetn_in),
  .pool_in(pool_in),
  .req_in(req_in),
  .rdata_out(rdata_out),
  .led_out(led_out)
);

// [test/tb.sv]
`timescale 1ns/100ps
module tb;
  import ledind_pkg::*;
  localparam int unsigned HALF = 4;
  localparam logic [15:0] ER [8] = '{16'h0, 16'h0, 16'h8, 16'h4, 16'h0, 16'h0, 16'h0, 16'h0};
  localparam logic [15:0] EG [8] = '{16'h0, 16'h8, 16'h0, 16'h0, 16'h4, 16'h0, 16'h0, 16'h0};
  logic              core_clk_in;
  logic              resetn_in;
  logic [POOL_W-1:0] pool_in;
  ledind_req_t       req_in;
  logic [DATA_W-1:0] rdata_out;
  ledind_led_t       led_out;
  int                num_errors;
  int                cmp_count;
  ledind_top #(.HALF_CYC(HALF)) dut (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .pool_in(pool_in),
    .req_in(req_in),
    .rdata_out(rdata_out),
    .led_out(led_out)
  );
  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk_in);
    req_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_in);
    req_in <= '0;
  endtask
  // The mask hides status bits whose value depends on the free-running blink phase
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
                        input logic [DATA_W-1:0] msk = '1);
    @(posedge core_clk_in);
    req_in <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_in);
    req_in <= '0;
    #1 check(rdata_out & msk, exp);
  endtask
  // Counting lit cycles over a whole blink period makes flash checks phase-free
  task automatic lit_chk(input logic [POOL_W-1:0] p, input int er, input int eg);
    logic [15:0] nr;
    logic [15:0] ng;
    nr = '0;
    ng = '0;
    @(posedge core_clk_in);
    pool_in <= p;
    repeat (3) @(posedge core_clk_in);
    repeat (2 * HALF) begin
      @(posedge core_clk_in);
      #1 nr = nr + led_out.red;
      ng = ng + led_out.green;
    end
    check({nr, ng}, {16'(er), 16'(eg)});
  endtask
  task automatic test_defaults;
    rd_chk(REG_CTRL, 32'h000f0030);
    rd_chk(REG_ASSIGN, 32'h000ffff0);
    rd_chk(8'h20, 32'h0);
    lit_chk(15'h0000, 0, 0);
    lit_chk(15'h0001, 4, 0);
    $display("test_defaults done");
  endtask
  task automatic test_or_invert;
    wr(REG_CTRL, 32'h000f0120);
    wr(REG_ASSIGN, 32'h000fff53);
    wr(REG_INVERT, 32'h00000002);
    lit_chk(15'h0000, 8, 0);
    lit_chk(15'h0020, 0, 8);
    lit_chk(15'h0028, 8, 0);
    lit_chk(15'h0021, 0, 8);
    wr(REG_INVERT, 32'h0000001c);
    rd_chk(REG_INVERT, 32'h0000001c);
    rd_chk(REG_ASSIGN, 32'h000fff53);
    lit_chk(15'h0000, 0, 8);
    lit_chk(15'h0020, 8, 0);
    $display("test_or_invert done");
  endtask
  task automatic test_colours;
    wr(REG_INVERT, 32'h0);
    for (int c = 0; c < 8; c++) begin
      wr(REG_CTRL, 32'h000f0000 | (32'(c) << CTRL_ACT_LSB));
      lit_chk(15'h0008, ER[c], EG[c]);
      wr(REG_CTRL, 32'h000f0000 | (32'(c) << CTRL_INACT_LSB));
      lit_chk(15'h0000, ER[c], EG[c]);
    end
    wr(REG_CTRL, 32'h000f0330);
    lit_chk(15'h0008, 4, 0);
    lit_chk(15'h0000, 4, 0);
    wr(REG_CTRL, 32'h000f0440);
    lit_chk(15'h0008, 0, 4);
    lit_chk(15'h0000, 0, 4);
    $display("test_colours done");
  endtask
  task automatic test_latch;
    wr(REG_CTRL, 32'h00070021);
    lit_chk(15'h0008, 8, 0);
    lit_chk(15'h0000, 8, 0);
    lit_chk(15'h0088, 8, 0);
    lit_chk(15'h0008, 8, 0);
    lit_chk(15'h0000, 8, 0);
    lit_chk(15'h0080, 0, 0);
    lit_chk(15'h0008, 8, 0);
    lit_chk(15'h0000, 8, 0);
    rd_chk(REG_CAUSE, 32'h00000001);
    rd_chk(REG_STATUS, 32'h00000026, 32'hffffffef);
    wr(REG_ACKSW, 32'h00000001);
    lit_chk(15'h0000, 0, 0);
    rd_chk(REG_CAUSE, 32'h00000000);
    rd_chk(REG_STATUS, 32'h00000000, 32'hffffffef);
    wr(REG_CTRL, 32'h00070020);
    lit_chk(15'h0008, 8, 0);
    lit_chk(15'h0000, 0, 0);
    $display("test_latch done");
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    complete_run;
  end
  initial begin
    num_errors = 0;
    cmp_count = 0;
    resetn_in = 1'b0;
    pool_in = '0;
    req_in = '0;
    repeat (3) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    test_defaults;
    test_or_invert;
    test_colours;
    test_latch;
    complete_run;
  end
endmodule
